// ===== hw/overcurrent_fault_response.v
`timescale 1ns/1ns
`include "ocp_defines.vh"

module overcurrent_fault_response (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  input  wire        unit_tick,
  input  wire        oc_detect,
  input  wire        below_floor,
  input  wire        unit_on,
  input  wire        bias_ok,
  input  wire        other_fault,
  input  wire        fault_clear,
  output reg  [15:0] current_limit,
  output reg         limit_active,
  output reg         output_enable,
  output reg         oc_fault_flag,
  output reg         host_alert,
  output reg         retry_exhausted
);
  localparam ST_RUN   = 3'd0;
  localparam ST_LIMIT = 3'd1;
  localparam ST_WAIT  = 3'd2;
  localparam ST_TRY   = 3'd3;
  localparam ST_LATCH = 3'd4;

  reg  [15:0] overcurrent_fault_threshold;
  reg  [7:0]  overcurrent_fault_action;
  reg  [2:0]  state;
  reg  [2:0]  tries;
  reg  [`OC_TICK_WIDTH-1:0] delay_cnt;
  reg  [7:0]  units;
  reg         tick_d;
  wire        oc_s;
  wire        floor_s;
  wire        on_s;
  wire        bias_s;
  wire        tick_s;
  wire        tick_pulse;
  wire [1:0]  resp;
  wire [2:0]  retry_cfg;
  wire [2:0]  delay_code;
  wire [7:0]  delay_units;
  wire        stop_all;

  ocp_sync3 u_sync_oc (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .din     (oc_detect),
    .dout    (oc_s)
  );
  ocp_sync3 u_sync_floor (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .din     (below_floor),
    .dout    (floor_s)
  );
  ocp_sync3 u_sync_on (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .din     (unit_on),
    .dout    (on_s)
  );
  ocp_sync3 u_sync_bias (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .din     (bias_ok),
    .dout    (bias_s)
  );
  ocp_sync3 u_sync_tick (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .din     (unit_tick),
    .dout    (tick_s)
  );

  assign resp        = overcurrent_fault_action[`OC_RESPONSE_MSB:`OC_RESPONSE_LSB];
  assign retry_cfg   = overcurrent_fault_action[`OC_RETRY_MSB:`OC_RETRY_LSB];
  assign delay_code  = overcurrent_fault_action[`OC_DELAY_MSB:`OC_DELAY_LSB];
  assign delay_units = 8'h01 << delay_code;
  assign tick_pulse  = tick_s & ~tick_d;
  // Other faults also end endless retry; command off or bias loss too
  assign stop_all    = ~on_s | ~bias_s | other_fault;

  // Register access; the action write also governs the response machine
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      overcurrent_fault_threshold <= `OC_THRESHOLD_RESET;
      overcurrent_fault_action    <= `OC_ACTION_RESET;
      reg_rdata                   <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `OC_THRESHOLD_ADDR) begin
        overcurrent_fault_threshold <= reg_wdata;
      end
      if (reg_wr && reg_addr == `OC_ACTION_ADDR) begin
        overcurrent_fault_action <= reg_wdata[7:0];
      end
      if (reg_rd) begin
        case (reg_addr)
          `OC_THRESHOLD_ADDR: reg_rdata <= overcurrent_fault_threshold;
          `OC_ACTION_ADDR:    reg_rdata <= {8'h00, overcurrent_fault_action};
          default:            reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state           <= ST_RUN;
      tries           <= 3'h0;
      units           <= 8'h00;
      delay_cnt       <= {`OC_TICK_WIDTH{1'b0}};
      tick_d          <= 1'b0;
      current_limit   <= `OC_THRESHOLD_RESET;
      limit_active    <= 1'b0;
      output_enable   <= 1'b0;
      oc_fault_flag   <= 1'b0;
      host_alert      <= 1'b0;
      retry_exhausted <= 1'b0;
    end else begin
      tick_d        <= tick_s;
      current_limit <= overcurrent_fault_threshold;
      // Set beats clear so a fresh fault in the clear cycle is kept
      if (oc_s) begin
        oc_fault_flag <= 1'b1;
        host_alert    <= 1'b1;
      end else if (fault_clear) begin
        oc_fault_flag <= 1'b0;
        host_alert    <= 1'b0;
      end
      case (state)
        ST_RUN: begin
          output_enable <= on_s & bias_s;
          limit_active  <= 1'b0;
          units         <= 8'h00;
          if (oc_s && on_s) begin
            case (resp)
              `OC_RESP_IGNORE: begin
                state        <= ST_LIMIT;
                limit_active <= 1'b1;
              end
              `OC_RESP_CONDITIONED: begin
                state        <= ST_LIMIT;
                limit_active <= 1'b1;
              end
              `OC_RESP_DELAYED: begin
                state        <= ST_LIMIT;
                limit_active <= 1'b1;
              end
              default: begin
                output_enable <= 1'b0;
                state         <= ST_WAIT;
              end
            endcase
          end
        end
        ST_LIMIT: begin
          limit_active <= 1'b1;
          if (tick_pulse) begin
            units <= units + 8'h01;
          end
          if (!oc_s) begin
            state <= ST_RUN;
          end else if (resp == `OC_RESP_CONDITIONED && floor_s) begin
            output_enable <= 1'b0;
            limit_active  <= 1'b0;
            units         <= 8'h00;
            state         <= ST_WAIT;
          end else if (resp == `OC_RESP_DELAYED && tick_pulse &&
                       units + 8'h01 >= delay_units) begin
            output_enable <= 1'b0;
            limit_active  <= 1'b0;
            units         <= 8'h00;
            state         <= ST_WAIT;
          end else if (resp == `OC_RESP_SHUTDOWN) begin
            output_enable <= 1'b0;
            limit_active  <= 1'b0;
            state         <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          output_enable <= 1'b0;
          limit_active  <= 1'b0;
          if (retry_cfg == `OC_RETRY_NONE) begin
            state <= ST_LATCH;
          end else if (retry_cfg != `OC_RETRY_ENDLESS &&
                       tries >= retry_cfg) begin
            state <= ST_LATCH;
          end else if (retry_cfg == `OC_RETRY_ENDLESS && stop_all) begin
            state <= ST_LATCH;
          end else if (tick_pulse) begin
            if (units + 8'h01 >= delay_units) begin
              units <= 8'h00;
              state <= ST_TRY;
              if (retry_cfg != `OC_RETRY_ENDLESS) begin
                tries <= tries + 3'h1;
              end
              output_enable <= 1'b1;
            end else begin
              units <= units + 8'h01;
            end
          end
        end
        ST_TRY: begin
          output_enable <= 1'b1;
          delay_cnt     <= delay_cnt + 1'b1;
          if (oc_s) begin
            output_enable <= 1'b0;
            delay_cnt     <= {`OC_TICK_WIDTH{1'b0}};
            state         <= ST_WAIT;
          end else if (tick_pulse) begin
            delay_cnt <= {`OC_TICK_WIDTH{1'b0}};
            state     <= ST_RUN;
          end
        end
        ST_LATCH: begin
          output_enable   <= 1'b0;
          retry_exhausted <= 1'b1;
          if (fault_clear && !oc_s) begin
            tries           <= 3'h0;
            retry_exhausted <= 1'b0;
            state           <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
      if (fault_clear && state != ST_LATCH && !oc_s) begin
        tries <= 3'h0;
      end
    end
  end
endmodule

// ===== common/ocp_defines.vh
`ifndef OCP_DEFINES_VH
`define OCP_DEFINES_VH
`define OC_THRESHOLD_ADDR      8'h46
`define OC_ACTION_ADDR         8'h47
`define OC_THRESHOLD_RESET     16'h0000
`define OC_ACTION_RESET        8'hC0
`define OC_RESPONSE_MSB        7
`define OC_RESPONSE_LSB        6
`define OC_RETRY_MSB           5
`define OC_RETRY_LSB           3
`define OC_DELAY_MSB           2
`define OC_DELAY_LSB           0
`define OC_RETRY_NONE          3'h0
`define OC_RETRY_ENDLESS       3'h7
`define OC_RESP_IGNORE         2'h0
`define OC_RESP_CONDITIONED    2'h1
`define OC_RESP_DELAYED        2'h2
`define OC_RESP_SHUTDOWN       2'h3
`define OC_TICK_WIDTH          24
`endif

// ===== hw/ocp_sync3.v
`timescale 1ns/1ns
// Three-stage synchroniser; output changes once stages two and three agree
module ocp_sync3 (
  input  wire clk_sys,
  input  wire sys_rst,
  input  wire din,
  output reg  dout
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

// ===== verification/ocp_stage_model.sv
`timescale 1ns/1ns
// Load draws too much only while the stage is enabled
module ocp_stage_model (
  input  logic clk_sys,
  input  logic overload,
  input  logic output_enable,
  output logic unit_tick,
  output logic oc_detect,
  output int   starts
);
  logic [3:0] div = 4'h0;
  initial unit_tick = 1'b0;
  initial starts = 0;
  assign oc_detect = overload & output_enable;
  always @(posedge clk_sys) begin
    div <= div + 4'h1;
    if (div == 4'hF)
      unit_tick <= ~unit_tick;
  end
  always @(posedge output_enable)
    starts = starts + 1;
endmodule

// ===== verification/ocp_checker_sva.sv
`timescale 1ns/1ns
module ocp_checker_sva (
  input logic        clk_sys,
  input logic        sys_rst,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [7:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata,
  input logic        oc_detect,
  input logic        fault_clear,
  input logic [15:0] current_limit,
  input logic        output_enable,
  input logic        oc_fault_flag,
  input logic        host_alert,
  input logic        retry_exhausted
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence thr_wr;
    reg_wr && reg_addr == 8'h46;
  endsequence
  sequence odd_rd;
    reg_rd && reg_addr != 8'h46 && reg_addr != 8'h47;
  endsequence
  sequence oc_held;
    $rose(oc_detect) ##1 oc_detect [*4];
  endsequence
  alert_follow_a: assert property (host_alert == oc_fault_flag)
    else $error("alert differs from flag");
  limit_copy_a: assert property (thr_wr |=> ##1
    current_limit == $past(reg_wdata, 2))
    else $error("threshold not copied");
  thr_read_a: assert property (reg_rd && reg_addr == 8'h46 |=>
    reg_rdata == current_limit)
    else $error("threshold readback wrong");
  odd_read_a: assert property (odd_rd |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  flag_rise_a: assert property (oc_held |-> ##[0:4] oc_fault_flag)
    else $error("fault flag missing");
  flag_hold_a: assert property (oc_fault_flag && !fault_clear |=> oc_fault_flag)
    else $error("fault flag dropped");
  off_hold_a: assert property (retry_exhausted && !fault_clear |=>
    retry_exhausted)
    else $error("latched off dropped");
  off_dark_a: assert property (retry_exhausted [*2] |-> !output_enable)
    else $error("output on while latched");
endmodule
bind overcurrent_fault_response ocp_checker_sva u_sva (.clk_sys, .sys_rst,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .oc_detect,
  .fault_clear, .current_limit, .output_enable, .oc_fault_flag,
  .host_alert, .retry_exhausted);

// ===== verification/overcurrent_fault_response_test.sv
`timescale 1ns/1ns
module overcurrent_fault_response_test;
  logic clk_sys, sys_rst, reg_wr, reg_rd, unit_tick, oc_detect, unit_on;
  logic bias_ok, other_fault, below_floor, fault_clear, overload;
  logic limit_active, output_enable, oc_fault_flag, host_alert;
  logic retry_exhausted;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, current_limit;
  int starts, s0, error_cnt = 0, total_checks = 0;
  overcurrent_fault_response i_dut (.clk_sys, .sys_rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .unit_tick, .oc_detect,
    .below_floor, .unit_on, .bias_ok, .other_fault, .fault_clear,
    .current_limit, .limit_active, .output_enable, .oc_fault_flag,
    .host_alert, .retry_exhausted);
  ocp_stage_model u_stage (.clk_sys, .overload, .output_enable, .unit_tick,
    .oc_detect, .starts);
  always #10 clk_sys = ~clk_sys;
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    chk("rdata", reg_rdata, exp);
  endtask
  // Comparator must settle low before the clear lands
  task automatic clear_fault;
    overload = 1'b0;
    below_floor = 1'b0;
    step(6);
    fault_clear = 1'b1;
    step(1);
    fault_clear = 1'b0;
    step(30);
  endtask
  task automatic t_regs;
    rd(8'h46, 16'h0000);
    rd(8'h47, 16'h00C0);
    wr(8'h46, 16'h1234);
    rd(8'h46, 16'h1234);
    chk("limit", current_limit, 16'h1234);
    wr(8'h48, 16'hFFFF);
    rd(8'h48, 16'h0000);
  endtask
  task automatic t_trip;
    step(10);
    chk("oe", output_enable, 1);
    overload = 1'b1;
    step(10);
    chk("oe", output_enable, 0);
    chk("flag", oc_fault_flag, 1);
    chk("alert", host_alert, 1);
    step(200);
    chk("off", retry_exhausted, 1);
    clear_fault();
    chk("flag", oc_fault_flag, 0);
  endtask
  task automatic t_modes;
    wr(8'h47, 16'h0000);
    overload = 1'b1;
    step(100);
    chk("lim", limit_active, 1);
    chk("oe", output_enable, 1);
    clear_fault();
    wr(8'h47, 16'h0040);
    overload = 1'b1;
    step(30);
    chk("oe", output_enable, 1);
    below_floor = 1'b1;
    step(10);
    chk("oe", output_enable, 0);
    clear_fault();
    wr(8'h47, 16'h0081);
    overload = 1'b1;
    step(20);
    chk("lim", limit_active, 1);
    step(150);
    chk("oe", output_enable, 0);
    clear_fault();
  endtask
  task automatic t_retry;
    for (int r = 1; r < 7; r++) begin
      wr(8'h47, {8'h00, 2'b11, r[2:0], 3'b000});
      s0 = starts;
      overload = 1'b1;
      for (int i = 0; i < 2000 && retry_exhausted !== 1'b1; i++)
        step(1);
      chk("tries", 16'(starts - s0), 16'(r));
      clear_fault();
    end
  endtask
  // Delay code 2 spaces attempts four unit ticks apart
  task automatic t_spacing;
    wr(8'h47, 16'h00CA);
    s0 = starts;
    overload = 1'b1;
    step(70);
    chk("early", 16'(starts - s0), 16'h0000);
    step(100);
    chk("spaced", 16'(starts - s0), 16'h0001);
    step(200);
    chk("off", retry_exhausted, 1);
    clear_fault();
  endtask
  task automatic t_endless;
    wr(8'h47, 16'h00F8);
    s0 = starts;
    overload = 1'b1;
    step(700);
    chk("off", retry_exhausted, 0);
    chk("many", starts - s0 > 8, 1);
    unit_on = 1'b0;
    step(10);
    s0 = starts;
    step(200);
    chk("stop", 16'(starts - s0), 0);
    unit_on = 1'b1;
    clear_fault();
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end
  initial begin
    {clk_sys, reg_wr, reg_rd, other_fault, below_floor} = '0;
    {fault_clear, overload, reg_addr, reg_wdata} = '0;
    {sys_rst, unit_on, bias_ok} = 3'b111;
    step(20);
    sys_rst = 1'b0;
    t_regs();
    t_trip();
    t_modes();
    t_retry();
    t_spacing();
    t_endless();
    summarize();
  end
endmodule
